// file: core/simr_regs.sv
// status, mask and acknowledge registers with the host interrupt line
`timescale 1ns/1ns
`default_nettype none
module simr_regs (
   input  wire logic                          clk,
   input  wire logic                          rst_n,
   input  wire logic [simr_pkg::ADDR_W-1:0]   reg_addr,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   input  wire logic [simr_pkg::DATA_W-1:0]   reg_wdata,
   output logic      [simr_pkg::DATA_W-1:0]   reg_rdata,
   input  wire logic [7:0]                    charger_status_in,
   input  wire logic [7:0]                    supply_fault_in,
   input  wire logic                          conversion_done_in,
   input  wire logic                          above_high_limit_in,
   input  wire logic                          below_low_limit_in,
   input  wire logic                          analog_input_one_hiz_in,
   input  wire logic                          thermal_fault_in,
   output logic                               conversion_result_high_b7,
   output simr_pkg::simr_charge_state_t       charge_state,
   output logic                               host_irq_n
);
   import simr_pkg::*;

   localparam int unsigned NSYNC = SV_WIDTH;

   logic [NSYNC-1:0] sync1_r, sync1_nxt, sync2_r, sync2_nxt, prev_r, prev_nxt;
   logic [7:0]       chg_r;
   logic             done_r;
   logic [7:0]       supply_mask_r, supply_mask_nxt, event_mask_r, event_mask_nxt;
   logic [7:0]       supply_ack_r, supply_ack_nxt, event_ack_r, event_ack_nxt;
   logic [7:0]       rdata_r, rdata_nxt;
   logic [1:0]       settle_r, settle_nxt;
   logic             irq_n_r, irq_n_nxt;
   logic [NSYNC-1:0] toggle;
   logic [7:0]       supply_ev, event_ev;
   logic             armed;

   assign chg_r  = sync2_r[SV_DISCH:SV_CHG_LO];
   assign done_r = sync2_r[SV_DONE];

   always_comb begin
      sync1_nxt = {charger_status_in, supply_fault_in, conversion_done_in,
                   above_high_limit_in, below_low_limit_in, analog_input_one_hiz_in, thermal_fault_in};
      sync2_nxt = sync1_r;
      prev_nxt  = sync2_r;
      // edge detection waits until prev_r holds real pin values, else reset looks like a toggle
      armed     = (settle_r == SETTLE_CYCLES);
      settle_nxt = armed ? settle_r : settle_r + 2'h1;
      toggle    = armed ? (sync2_r ^ prev_r) : '0;
      // discharge bit left out of the charger event to avoid chatter in supplement mode
      event_ev = ZERO_BYTE;
      event_ev[EV_CONV_DONE]   = toggle[SV_DONE] & ~event_mask_r[EV_CONV_DONE];
      event_ev[EV_ABOVE_HI]    = toggle[SV_HI] & ~event_mask_r[EV_ABOVE_HI];
      event_ev[EV_BELOW_LO]    = toggle[SV_LO] & ~event_mask_r[EV_BELOW_LO];
      event_ev[EV_ANALOG1_HIZ] = toggle[SV_HIZ] & ~event_mask_r[EV_ANALOG1_HIZ];
      event_ev[EV_THERMAL]     = toggle[SV_THERM] & ~event_mask_r[EV_THERMAL];
      event_ev[EV_CHARGER]     = (|toggle[SV_CHG_HI:SV_CHG_LO]) & ~event_mask_r[EV_CHARGER];
      supply_ev = toggle[SV_FAULT_HI:SV_FAULT_LO] & ~supply_mask_r;

      supply_mask_nxt = supply_mask_r;
      event_mask_nxt  = event_mask_r;
      supply_ack_nxt  = supply_ack_r;
      event_ack_nxt   = event_ack_r;
      if (reg_wr) begin
         unique case (reg_addr)
            ADDR_SUPPLY_MASK: supply_mask_nxt = reg_wdata;
            ADDR_EVENT_MASK:  event_mask_nxt  = reg_wdata;
            ADDR_SUPPLY_ACK:  supply_ack_nxt  = supply_ack_r & reg_wdata;
            ADDR_EVENT_ACK:   event_ack_nxt   = event_ack_r & reg_wdata;
            default: ;
         endcase
      end
      // acks only capture while the line is high; changes seen while low are dropped
      if (irq_n_r) begin
         supply_ack_nxt = supply_ack_nxt | supply_ev;
         event_ack_nxt  = event_ack_nxt | event_ev;
      end
      irq_n_nxt = ~(|{supply_ack_nxt, event_ack_nxt});

      // registered read data stands until the next read strobe
      rdata_nxt = rdata_r;
      if (reg_rd) begin
         unique case (reg_addr)
            ADDR_SUPPLY_MASK: rdata_nxt = supply_mask_r;
            ADDR_EVENT_MASK:  rdata_nxt = event_mask_r;
            ADDR_SUPPLY_ACK:  rdata_nxt = supply_ack_r;
            ADDR_EVENT_ACK:   rdata_nxt = event_ack_r;
            ADDR_CHG_STATUS:  rdata_nxt = chg_r;
            default:          rdata_nxt = ZERO_BYTE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_r       <= '0;
         sync2_r       <= '0;
         prev_r        <= '0;
         settle_r      <= 2'h0;
         // all masked out of reset so nothing fires before the host sets up
         supply_mask_r <= MASK_RESET;
         event_mask_r  <= MASK_RESET;
         supply_ack_r  <= ZERO_BYTE;
         event_ack_r   <= ZERO_BYTE;
         rdata_r       <= ZERO_BYTE;
         irq_n_r       <= 1'b1;
      end else begin
         sync1_r       <= sync1_nxt;
         sync2_r       <= sync2_nxt;
         prev_r        <= prev_nxt;
         settle_r      <= settle_nxt;
         supply_mask_r <= supply_mask_nxt;
         event_mask_r  <= event_mask_nxt;
         supply_ack_r  <= supply_ack_nxt;
         event_ack_r   <= event_ack_nxt;
         rdata_r       <= rdata_nxt;
         irq_n_r       <= irq_n_nxt;
      end
   end

   assign reg_rdata                 = rdata_r;
   assign host_irq_n                = irq_n_r;
   assign conversion_result_high_b7 = done_r;
   assign charge_state = simr_charge_state_t'(chg_r[CHG_STATE_HI:CHG_STATE_LO]);

   // interrupt path and register read checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_line_follows_acks;
      host_irq_n == ~(|{supply_ack_r, event_ack_r});
   endproperty
   a_line_follows_acks: assert property (p_line_follows_acks) else $error("line disagrees with acks");

   property p_masked_supply_no_ack;
      (irq_n_r && supply_mask_r[7] && !(reg_wr && reg_addr == ADDR_SUPPLY_MASK) && !supply_ack_r[7])
         |=> !supply_ack_r[7];
   endproperty
   a_masked_supply_no_ack: assert property (p_masked_supply_no_ack) else $error("masked supply acked");

   property p_unmasked_supply_acks;
      (irq_n_r && armed && toggle[SV_FAULT_HI] && !supply_mask_r[7]) |=> (supply_ack_r[7] && !host_irq_n);
   endproperty
   a_unmasked_supply_acks: assert property (p_unmasked_supply_acks) else $error("supply fault not acked");

   property p_latched_while_low;
      (!host_irq_n && !reg_wr) |=> ($stable(supply_ack_r) && $stable(event_ack_r));
   endproperty
   a_latched_while_low: assert property (p_latched_while_low) else $error("acks changed while low");

   property p_clear_releases;
      (!host_irq_n && reg_wr && reg_addr == ADDR_SUPPLY_ACK && reg_wdata == ZERO_BYTE
         && event_ack_r == ZERO_BYTE) |=> host_irq_n;
   endproperty
   a_clear_releases: assert property (p_clear_releases) else $error("line not released");

   property p_discharge_only_silent;
      (irq_n_r && armed && toggle[SV_DISCH] && !(|toggle[SV_CHG_HI:SV_THERM]) && supply_ack_r == ZERO_BYTE
         && event_ack_r == ZERO_BYTE) |=> host_irq_n;
   endproperty
   a_discharge_only_silent: assert property (p_discharge_only_silent) else $error("discharge raised irq");

   property p_thermal_event;
      (irq_n_r && armed && toggle[SV_THERM] && !event_mask_r[EV_THERMAL]) |=> event_ack_r[EV_THERMAL];
   endproperty
   a_thermal_event: assert property (p_thermal_event) else $error("thermal event lost");

   property p_conv_done_event;
      (irq_n_r && armed && toggle[SV_DONE] && !event_mask_r[EV_CONV_DONE]) |=> event_ack_r[EV_CONV_DONE];
   endproperty
   a_conv_done_event: assert property (p_conv_done_event) else $error("conversion event lost");

   property p_status_read;
      (reg_rd && reg_addr == ADDR_CHG_STATUS) |=> reg_rdata == $past(chg_r);
   endproperty
   a_status_read: assert property (p_status_read) else $error("charger status read wrong");

   property p_no_new_while_low;
      $fell(host_irq_n) |-> ($past(supply_ack_r) == ZERO_BYTE && $past(event_ack_r) == ZERO_BYTE);
   endproperty
   a_no_new_while_low: assert property (p_no_new_while_low) else $error("irq fell over stale acks");

   property p_release_by_host;
      $rose(host_irq_n) |-> $past(reg_wr);
   endproperty
   a_release_by_host: assert property (p_release_by_host) else $error("line rose without host write");

   property p_mask_write;
      (reg_wr && reg_addr == ADDR_SUPPLY_MASK) |=> supply_mask_r == $past(reg_wdata);
   endproperty
   a_mask_write: assert property (p_mask_write) else $error("supply mask write lost");

   property p_rdata_holds;
      !reg_rd |=> $stable(reg_rdata);
   endproperty
   a_rdata_holds: assert property (p_rdata_holds) else $error("read data moved without read");

   property p_masked_event_no_ack;
      (irq_n_r && event_mask_r[EV_THERMAL] && !event_ack_r[EV_THERMAL]) |=> !event_ack_r[EV_THERMAL];
   endproperty
   a_masked_event_no_ack: assert property (p_masked_event_no_ack) else $error("masked thermal acked");

   property p_charger_event;
      (irq_n_r && (|toggle[SV_CHG_HI:SV_CHG_LO]) && !event_mask_r[EV_CHARGER]) |=> event_ack_r[EV_CHARGER];
   endproperty
   a_charger_event: assert property (p_charger_event) else $error("charger event lost");

   c_supply_irq:  cover property ($fell(host_irq_n) && supply_ack_r != ZERO_BYTE);
   c_event_irq:   cover property ($fell(host_irq_n) && event_ack_r != ZERO_BYTE);
   c_release:     cover property ($rose(host_irq_n));
   c_charger_irq: cover property ($fell(host_irq_n) && event_ack_r[EV_CHARGER]);
endmodule : simr_regs
`default_nettype wire

// file: core/simr_pkg.sv
// constants shared by the status and interrupt mask register block
package simr_pkg;
   localparam int unsigned DATA_W           = 8;
   localparam int unsigned ADDR_W           = 8;
   localparam logic [7:0]  ADDR_SUPPLY_MASK = 8'h03;
   localparam logic [7:0]  ADDR_EVENT_MASK  = 8'h04;
   localparam logic [7:0]  ADDR_SUPPLY_ACK  = 8'h05;
   localparam logic [7:0]  ADDR_EVENT_ACK   = 8'h06;
   localparam logic [7:0]  ADDR_CHG_STATUS  = 8'h0a;
   localparam logic [7:0]  MASK_RESET       = 8'hff;
   localparam logic [7:0]  ZERO_BYTE        = 8'h00;
   // charger status bit positions
   localparam int unsigned CHG_DISCHARGE    = 7;
   localparam int unsigned CHG_INPUT_SEL    = 6;
   localparam int unsigned CHG_THERM_PPATH  = 5;
   localparam int unsigned CHG_WALL_PRES    = 4;
   localparam int unsigned CHG_BUS_PRES     = 3;
   localparam int unsigned CHG_STATE_HI     = 2;
   localparam int unsigned CHG_STATE_LO     = 1;
   localparam int unsigned CHG_INPUT_OV     = 0;
   // event mask and event acknowledge bit positions
   localparam int unsigned EV_CONV_DONE     = 7;
   localparam int unsigned EV_ANALOG1_HIZ   = 6;
   localparam int unsigned EV_THERMAL       = 3;
   localparam int unsigned EV_CHARGER       = 2;
   localparam int unsigned EV_ABOVE_HI      = 1;
   localparam int unsigned EV_BELOW_LO      = 0;
   // positions inside the synchronised status vector
   localparam int unsigned SV_THERM         = 0;
   localparam int unsigned SV_HIZ           = 1;
   localparam int unsigned SV_LO            = 2;
   localparam int unsigned SV_HI            = 3;
   localparam int unsigned SV_DONE          = 4;
   localparam int unsigned SV_FAULT_LO      = 5;
   localparam int unsigned SV_FAULT_HI      = 12;
   localparam int unsigned SV_CHG_LO        = 13;
   localparam int unsigned SV_CHG_HI        = 19;
   localparam int unsigned SV_DISCH         = 20;
   localparam int unsigned SV_WIDTH         = 21;
   localparam logic [1:0]  SETTLE_CYCLES    = 2'h3;
   typedef enum logic [1:0] {
      SIMR_CHG_FAULT_OFF = 2'h0,
      SIMR_CHG_DONE      = 2'h1,
      SIMR_CHG_FAST      = 2'h2,
      SIMR_CHG_PRECHARGE = 2'h3
   } simr_charge_state_t;
endpackage : simr_pkg

// file: verif/simr_host_model.sv
// host model: byte register accesses and interrupt service
`timescale 1ns/1ns
`default_nettype none
module simr_host_model (
   input  wire logic       clk,
   input  wire logic [7:0] reg_rdata,
   output logic      [7:0] reg_addr,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic      [7:0] reg_wdata
);
   initial begin
      reg_addr  = 8'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_wdata = 8'h00;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(negedge clk);
      reg_wr    = 1'b0;
      // released lines never show the last value
      reg_addr  = ~a;
      reg_wdata = ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_rd   = 1'b1;
      @(negedge clk);
      reg_rd   = 1'b0;
      reg_addr = ~a;
      d        = reg_rdata;
   endtask : rd
   task automatic ack_clear(input logic [7:0] a);
      wr(a, 8'h00);
   endtask : ack_clear
endmodule : simr_host_model
`default_nettype wire

// file: verif/test_status_and_irq_mask_regs.sv
// self-checking bench for the status and interrupt mask registers
`timescale 1ns/1ns
`default_nettype none
module test_status_and_irq_mask_regs;
   import simr_pkg::*;
   logic clk, rst_n, wr, rd, irq_n, b7;
   logic [7:0] addr, wdata, rdata, chg, sup, got;
   logic [4:0] ev;
   simr_charge_state_t cs;
   int fails, cmp_count;
   localparam logic [7:0] EV_ACK [5] = '{8'h01, 8'h02, 8'h08, 8'h40, 8'h80};
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   simr_host_model host (.clk(clk), .reg_rdata(rdata), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
                         .reg_wdata(wdata));
   simr_regs dut (.clk(clk), .rst_n(rst_n), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata),
      .reg_rdata(rdata), .charger_status_in(chg), .supply_fault_in(sup), .conversion_done_in(ev[4]),
      .analog_input_one_hiz_in(ev[3]), .thermal_fault_in(ev[2]), .above_high_limit_in(ev[1]),
      .below_low_limit_in(ev[0]), .conversion_result_high_b7(b7), .charge_state(cs), .host_irq_n(irq_n));
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic summarize;
      if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : summarize
   // sync chain plus detect edge fits well inside six cycles
   task automatic settle;
      repeat (6) @(negedge clk);
   endtask : settle
   task automatic t_status;
      host.rd(ADDR_SUPPLY_MASK, got);
      chk(got, MASK_RESET);
      chk({7'h0, irq_n}, 8'h01);
      chk({7'h0, b7}, 8'h00);
      for (int i = 0; i < 4; i++) begin
         chg = {5'b10101, 2'(i), 1'b0};
         settle();
         host.rd(ADDR_CHG_STATUS, got);
         chk(got, chg);
         chk({6'h0, cs}, {6'h0, 2'(i)});
      end
      host.wr(ADDR_CHG_STATUS, 8'h00);
      host.rd(ADDR_CHG_STATUS, got);
      chk(got, chg);
      host.rd(8'h20, got);
      chk(got, 8'h00);
   endtask : t_status
   task automatic t_supply;
      host.wr(ADDR_SUPPLY_MASK, 8'h7e);
      host.rd(ADDR_SUPPLY_MASK, got);
      chk(got, 8'h7e);
      sup[6] = 1'b1;
      settle();
      chk({7'h0, irq_n}, 8'h01);
      sup[7] = 1'b1;
      settle();
      chk({7'h0, irq_n}, 8'h00);
      sup[0] = 1'b1;
      settle();
      host.rd(ADDR_SUPPLY_ACK, got);
      chk(got, 8'h80);
      host.ack_clear(ADDR_SUPPLY_ACK);
      chk({7'h0, irq_n}, 8'h01);
      sup[0] = 1'b0;
      settle();
      host.rd(ADDR_SUPPLY_ACK, got);
      chk(got, 8'h01);
      host.ack_clear(ADDR_SUPPLY_ACK);
   endtask : t_supply
   task automatic t_events;
      host.wr(ADDR_EVENT_MASK, 8'h00);
      chg[7] = ~chg[7];
      settle();
      chk({7'h0, irq_n}, 8'h01);
      chg[CHG_INPUT_SEL] = ~chg[CHG_INPUT_SEL];
      settle();
      chk({7'h0, irq_n}, 8'h00);
      host.rd(ADDR_EVENT_ACK, got);
      chk(got, 8'h04);
      host.ack_clear(ADDR_EVENT_ACK);
      chk({7'h0, irq_n}, 8'h01);
      for (int k = 0; k < 5; k++) begin
         ev[k] = 1'b1;
         settle();
         chk({7'h0, irq_n}, 8'h00);
         host.rd(ADDR_EVENT_ACK, got);
         chk(got, EV_ACK[k]);
         host.ack_clear(ADDR_EVENT_ACK);
      end
      chk({7'h0, b7}, 8'h01);
      host.wr(ADDR_EVENT_MASK, 8'h08);
      host.rd(ADDR_EVENT_MASK, got);
      chk(got, 8'h08);
      ev[2] = 1'b0;
      settle();
      chk({7'h0, irq_n}, 8'h01);
      host.rd(ADDR_EVENT_ACK, got);
      chk(got, 8'h00);
   endtask : t_events
   initial begin
      rst_n = 1'b0;
      chg   = 8'h00;
      sup   = 8'h00;
      ev    = 5'h00;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      settle();
      t_status();
      t_supply();
      t_events();
      summarize();
   end
   initial begin
      #200000;
      fails++;
      summarize();
   end
endmodule : test_status_and_irq_mask_regs
`default_nettype wire
